/* File: src/ddds_pkg.sv */
package ddds_pkg;

	localparam int unsigned ADDR_W = 5;

	localparam logic [ADDR_W-1:0] ADDR_CTRL   = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_CMD    = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_WDATA  = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h0c;
	localparam logic [ADDR_W-1:0] ADDR_RDATA  = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_LEN    = 5'h14;

	localparam int unsigned CTRL_ITYPE_LSB = 0;
	localparam int unsigned CTRL_ECC_BIT   = 2;
	localparam int unsigned CTRL_IDX_BIT   = 3;
	localparam int unsigned CTRL_HARD_BIT  = 4;
	localparam int unsigned CTRL_HEAD_LSB  = 8;

	localparam int unsigned CMD_READ_BIT  = 0;
	localparam int unsigned CMD_WRITE_BIT = 1;
	localparam int unsigned CMD_ABORT_BIT = 2;

	localparam int unsigned STAT_BUSY_BIT   = 0;
	localparam int unsigned STAT_LOADED_BIT = 1;
	localparam int unsigned STAT_FOUND_BIT  = 2;
	localparam int unsigned STAT_EXTERNAL_CHECK_ERROR_BIT = 3;
	localparam int unsigned STAT_RVLD_BIT   = 4;
	localparam int unsigned STAT_WNEED_BIT  = 5;
	localparam int unsigned STAT_LINK_BIT   = 6;
	localparam int unsigned STAT_REVS_LSB   = 8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [15:0] LEN_RESET = 16'h0200;

	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned HLOAD_SAMPLE_CLKS  = 8;
	localparam int unsigned REFCLK_SETTLE_CLKS = 16;

	typedef enum logic [1:0] {
		DDDS_FLOPPY = 2'h0,
		DDDS_MFM    = 2'h1,
		DDDS_ESDI   = 2'h2
	} ddds_itype_t;

	localparam logic [1:0] ECC_IDLE  = 2'h0;
	localparam logic [1:0] ECC_RESET = 2'h1;
	localparam logic [1:0] ECC_GEN   = 2'h3;
	localparam logic [1:0] ECC_CHECK = 2'h2;

	localparam logic [1:0] MARK_INDEX  = 2'h0;
	localparam logic [1:0] MARK_NORMAL = 2'h2;

	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_HLOAD = 7'h02,
		ST_HWAIT = 7'h04,
		ST_MARK  = 7'h08,
		ST_DATA  = 7'h10,
		ST_POST  = 7'h20,
		ST_END   = 7'h40
	} ddds_state_t;

	localparam int unsigned SYNC_N     = 7;
	localparam int unsigned SYNC_REF   = 0;
	localparam int unsigned SYNC_INDEX = 1;
	localparam int unsigned SYNC_MARK  = 2;
	localparam int unsigned SYNC_SC    = 3;
	localparam int unsigned SYNC_RD    = 4;
	localparam int unsigned SYNC_ERR   = 5;
	localparam int unsigned SYNC_RDY_N = 6;

endpackage

/* File: src/ddds_link_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface ddds_link_if;
	logic refclk;
	logic refclk_rise;
	logic index_rise;
	logic mark;
	logic mark_rise;
	logic sc;
	logic rd;
	logic err;
	logic ready_n;

	modport src (output refclk, refclk_rise, index_rise, mark, mark_rise, sc, rd, err, ready_n);
	modport dst (input refclk, refclk_rise, index_rise, mark, mark_rise, sc, rd, err, ready_n);
endinterface

`default_nettype wire

/* File: src/ddds_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module ddds_sync #(
	parameter int unsigned N = ddds_pkg::SYNC_N
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] raw,
	ddds_link_if.src          link
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic         ref_d;
		logic         idx_d;
		logic         mark_d;
	} ddds_sync_t;

	ddds_sync_t q;
	ddds_sync_t d;

	// first stage feeds only the second stage
	always_comb begin
		d        = q;
		d.s1     = raw;
		d.s2     = q.s1;
		d.ref_d  = q.s2[ddds_pkg::SYNC_REF];
		d.idx_d  = q.s2[ddds_pkg::SYNC_INDEX];
		d.mark_d = q.s2[ddds_pkg::SYNC_MARK];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign link.refclk      = q.s2[ddds_pkg::SYNC_REF];
	assign link.refclk_rise = q.s2[ddds_pkg::SYNC_REF] && !q.ref_d;
	assign link.index_rise  = q.s2[ddds_pkg::SYNC_INDEX] && !q.idx_d;
	assign link.mark        = q.s2[ddds_pkg::SYNC_MARK];
	assign link.mark_rise   = q.s2[ddds_pkg::SYNC_MARK] && !q.mark_d;
	assign link.sc          = q.s2[ddds_pkg::SYNC_SC];
	assign link.rd          = q.s2[ddds_pkg::SYNC_RD];
	assign link.err         = q.s2[ddds_pkg::SYNC_ERR];
	assign link.ready_n     = q.s2[ddds_pkg::SYNC_RDY_N];
endmodule

`default_nettype wire

/* File: src/ddds_top.sv */
`timescale 1ns/1ns
`default_nettype none

module ddds_top #(
	parameter int unsigned POSTAMBLE_BITS = 16
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [ddds_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [ddds_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         read_reference_clock,
	input  wire logic                         index_in,
	input  wire logic                         mark_found_in,
	input  wire logic                         seek_complete_in,
	input  wire logic                         serial_read_in,
	input  wire logic                         external_check_error,
	input  wire logic                         drive_ready_ack_n,
	output logic [3:0]                        head_number_out,
	output logic                              mark_control_out,
	output logic                              read_gate,
	output logic                              write_gate,
	output logic                              write_clock_out,
	output logic                              serial_write_out,
	output logic [1:0]                        external_check_control
);
	typedef struct packed {
		logic                        awready;
		logic                        wready;
		logic                        aw_ok;
		logic [ddds_pkg::ADDR_W-1:0] aw_addr;
		logic                        w_ok;
		logic [31:0]                 w_data;
		logic [3:0]                  w_strb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        arready;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [1:0]                  rresp;
		ddds_pkg::ddds_itype_t       itype;
		logic                        ecc_en;
		logic                        idx_sel;
		logic                        hard_sector_pulse_in;
		logic [3:0]                  head;
		logic [15:0]                 len;
		logic [7:0]                  wbuf;
		logic                        wneed;
		logic [7:0]                  rbuf;
		logic                        rvld;
		logic [7:0]                  shreg;
		logic [2:0]                  bitcnt;
		logic [15:0]                 bytes;
		logic [15:0]                 post;
		logic [3:0]                  wait_cnt;
		logic [4:0]                  rdy_cnt;
		ddds_pkg::ddds_state_t       st;
		logic                        op_wr;
		logic                        armed;
		logic                        loaded;
		logic                        found;
		logic                        ecc_bad;
		logic [7:0]                  revs;
		logic [3:0]                  hsel;
		logic                        mctl;
		logic                        rg;
		logic                        wg;
		logic                        wclk;
		logic                        wdat;
		logic [1:0]                  eccc;
	} ddds_regs_t;

	ddds_regs_t q;
	ddds_regs_t d;

	ddds_link_if link ();

	ddds_sync #(
		.N (ddds_pkg::SYNC_N)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     ({drive_ready_ack_n, external_check_error, serial_read_in,
		             seek_complete_in, mark_found_in, index_in, read_reference_clock}),
		.link    (link.src)
	);

	function automatic logic reg_known(input logic [ddds_pkg::ADDR_W-1:0] a);
		reg_known = (a == ddds_pkg::ADDR_CTRL) || (a == ddds_pkg::ADDR_CMD) ||
		            (a == ddds_pkg::ADDR_WDATA) || (a == ddds_pkg::ADDR_STATUS) ||
		            (a == ddds_pkg::ADDR_RDATA) || (a == ddds_pkg::ADDR_LEN);
	endfunction

	// one step along 00-01-11-10-00 so decoders never see a glitch
	function automatic logic [1:0] gray_next(input logic [1:0] c);
		case (c)
			ddds_pkg::ECC_IDLE:  gray_next = ddds_pkg::ECC_RESET;
			ddds_pkg::ECC_RESET: gray_next = ddds_pkg::ECC_GEN;
			ddds_pkg::ECC_GEN:   gray_next = ddds_pkg::ECC_CHECK;
			default:             gray_next = ddds_pkg::ECC_IDLE;
		endcase
	endfunction

	logic        link_ok;
	logic        ecc_mode;
	logic        rise;
	logic        busy;
	logic        hit;
	logic        do_bit;
	logic [7:0]  cur;
	logic [7:0]  nsh;
	logic        start_rd;
	logic        start_wr;
	logic        abort;
	logic [31:0] status_w;

	always_comb begin
		d        = q;
		link_ok  = (q.rdy_cnt == 5'(ddds_pkg::REFCLK_SETTLE_CLKS)) && !link.ready_n;
		ecc_mode = q.ecc_en && (q.itype != ddds_pkg::DDDS_FLOPPY);
		rise     = link.refclk_rise;
		busy     = (q.st != ddds_pkg::ST_IDLE);
		start_rd = 1'b0;
		start_wr = 1'b0;
		abort    = 1'b0;
		status_w = 32'h0000_0000;
		status_w[ddds_pkg::STAT_BUSY_BIT]   = busy;
		status_w[ddds_pkg::STAT_LOADED_BIT] = q.loaded;
		status_w[ddds_pkg::STAT_FOUND_BIT]  = q.found;
		status_w[ddds_pkg::STAT_EXTERNAL_CHECK_ERROR_BIT] = q.ecc_bad;
		status_w[ddds_pkg::STAT_RVLD_BIT]   = q.rvld;
		status_w[ddds_pkg::STAT_WNEED_BIT]  = q.wneed;
		status_w[ddds_pkg::STAT_LINK_BIT]   = link_ok;
		status_w[ddds_pkg::STAT_REVS_LSB +: 8] = q.revs;

		// refclk is only trusted a settle time after the drive acknowledges
		if (link.ready_n) begin
			d.rdy_cnt = 5'h00;
		end else if (q.rdy_cnt != 5'(ddds_pkg::REFCLK_SETTLE_CLKS)) begin
			d.rdy_cnt = q.rdy_cnt + 5'h01;
		end

		// write channel: address and data may come in either order
		if (q.awready && s_axi_awvalid) begin
			d.aw_ok   = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (q.wready && s_axi_wvalid) begin
			d.w_ok   = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_ok && q.w_ok && !q.bvalid) begin
			d.aw_ok  = 1'b0;
			d.w_ok   = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = reg_known(q.aw_addr) ? ddds_pkg::RESP_OKAY : ddds_pkg::RESP_SLVERR;
			case (q.aw_addr)
				ddds_pkg::ADDR_CTRL: begin
					// mode bits frozen during an operation
					if (!busy && q.w_strb[0]) begin
						d.itype     = ddds_pkg::ddds_itype_t'(q.w_data[ddds_pkg::CTRL_ITYPE_LSB +: 2]);
						d.ecc_en    = q.w_data[ddds_pkg::CTRL_ECC_BIT];
						d.idx_sel   = q.w_data[ddds_pkg::CTRL_IDX_BIT];
						d.hard_sector_pulse_in = q.w_data[ddds_pkg::CTRL_HARD_BIT];
					end
					if (!busy && q.w_strb[1]) begin
						d.head = q.w_data[ddds_pkg::CTRL_HEAD_LSB +: 4];
					end
				end
				ddds_pkg::ADDR_CMD: begin
					if (q.w_strb[0]) begin
						start_rd = q.w_data[ddds_pkg::CMD_READ_BIT];
						start_wr = q.w_data[ddds_pkg::CMD_WRITE_BIT];
						abort    = q.w_data[ddds_pkg::CMD_ABORT_BIT];
					end
				end
				ddds_pkg::ADDR_WDATA: begin
					if (q.w_strb[0]) begin
						d.wbuf  = q.w_data[7:0];
						d.wneed = 1'b0;
					end
				end
				ddds_pkg::ADDR_LEN: begin
					if (!busy && q.w_strb[0]) d.len[7:0] = q.w_data[7:0];
					if (!busy && q.w_strb[1]) d.len[15:8] = q.w_data[15:8];
				end
				default: begin
				end
			endcase
		end
		d.awready = !d.aw_ok && !d.bvalid;
		d.wready  = !d.w_ok && !d.bvalid;

		// read channel, one outstanding read
		if (q.rvalid && s_axi_rready) begin
			d.rvalid  = 1'b0;
			d.arready = 1'b1;
		end
		if (q.arready && s_axi_arvalid) begin
			d.arready = 1'b0;
			d.rvalid  = 1'b1;
			d.rresp   = reg_known(s_axi_araddr) ? ddds_pkg::RESP_OKAY : ddds_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				ddds_pkg::ADDR_CTRL: begin
					d.rdata = 32'h0000_0000;
					d.rdata[ddds_pkg::CTRL_ITYPE_LSB +: 2] = q.itype;
					d.rdata[ddds_pkg::CTRL_ECC_BIT]        = q.ecc_en;
					d.rdata[ddds_pkg::CTRL_IDX_BIT]        = q.idx_sel;
					d.rdata[ddds_pkg::CTRL_HARD_BIT]       = q.hard_sector_pulse_in;
					d.rdata[ddds_pkg::CTRL_HEAD_LSB +: 4]  = q.head;
				end
				ddds_pkg::ADDR_WDATA:  d.rdata = {24'h00_0000, q.wbuf};
				ddds_pkg::ADDR_STATUS: d.rdata = status_w;
				ddds_pkg::ADDR_RDATA: begin
					d.rdata = {24'h00_0000, q.rbuf};
					d.rvld  = 1'b0;
				end
				ddds_pkg::ADDR_LEN:    d.rdata = {16'h0000, q.len};
				default:               d.rdata = 32'h0000_0000;
			endcase
		end

		if (busy && link.index_rise && (q.revs != 8'hff)) begin
			d.revs = q.revs + 8'h01;
		end

		// in esdi hard-sectored mode the sector pulse replaces the mark handshake
		hit    = (q.itype == ddds_pkg::DDDS_ESDI && q.hard_sector_pulse_in) ? link.mark_rise : link.mark;
		do_bit = rise && ((q.st == ddds_pkg::ST_DATA) ||
		                  (q.st == ddds_pkg::ST_MARK && q.armed && hit));
		cur    = (q.bitcnt == 3'h0) ? q.wbuf : q.shreg;
		nsh    = q.op_wr ? {cur[6:0], 1'b0} : {q.shreg[6:0], link.rd};

		case (q.st)
			ddds_pkg::ST_IDLE: begin
				if (link_ok && (start_rd || start_wr)) begin
					d.op_wr    = start_wr;
					d.bytes    = q.len;
					d.revs     = 8'h00;
					d.found    = 1'b0;
					d.ecc_bad  = 1'b0;
					d.armed    = 1'b0;
					d.bitcnt   = 3'h0;
					d.wait_cnt = 4'h0;
					d.loaded   = 1'b0;
					d.st       = (q.itype == ddds_pkg::DDDS_FLOPPY) ? ddds_pkg::ST_HLOAD
					                                                : ddds_pkg::ST_MARK;
				end
			end
			ddds_pkg::ST_HLOAD: begin
				d.wait_cnt = q.wait_cnt + 4'h1;
				if (q.wait_cnt == 4'(ddds_pkg::HLOAD_SAMPLE_CLKS - 1)) begin
					d.loaded = link.sc;
					d.st     = link.sc ? ddds_pkg::ST_MARK : ddds_pkg::ST_HWAIT;
				end
			end
			ddds_pkg::ST_HWAIT: begin
				if (link.sc) begin
					d.loaded = 1'b1;
					d.st     = ddds_pkg::ST_MARK;
				end
			end
			ddds_pkg::ST_MARK: begin
				if (rise && !q.armed) begin
					d.armed = 1'b1;
					d.wg    = q.op_wr;
					// esdi searches for a mark with read gate still low
					d.rg    = !q.op_wr && (q.itype != ddds_pkg::DDDS_ESDI);
					d.mctl  = !(q.itype == ddds_pkg::DDDS_ESDI && q.hard_sector_pulse_in);
					if (ecc_mode) d.eccc = gray_next(q.eccc);
				end else if (do_bit) begin
					d.found = 1'b1;
					d.mctl  = 1'b0;
					d.rg    = !q.op_wr;
					if (ecc_mode) d.eccc = gray_next(q.eccc);
					d.st    = ddds_pkg::ST_DATA;
				end
			end
			ddds_pkg::ST_POST: begin
				if (rise) begin
					d.wdat = 1'b0;
					d.post = q.post + 16'h0001;
					if (q.post == 16'(POSTAMBLE_BITS - 1)) begin
						d.ecc_bad = ecc_mode && !q.op_wr && link.err;
						d.st      = ddds_pkg::ST_END;
					end
				end
			end
			ddds_pkg::ST_END: begin
				// ecc pair finishes its walk before the gates drop
				if (rise) begin
					if (ecc_mode && q.eccc != ddds_pkg::ECC_IDLE) begin
						d.eccc = gray_next(q.eccc);
					end else begin
						d.rg    = 1'b0;
						d.wg    = 1'b0;
						d.mctl  = 1'b0;
						d.wdat  = 1'b0;
						d.armed = 1'b0;
						d.st    = ddds_pkg::ST_IDLE;
					end
				end
			end
			default: begin
			end
		endcase

		// one bit cell per refclk rise; first cell rides on the mark found edge
		if (do_bit) begin
			d.shreg  = nsh;
			d.bitcnt = q.bitcnt + 3'h1;
			if (q.op_wr) begin
				d.wdat = cur[7];
				if (q.bitcnt == 3'h0) d.wneed = 1'b1;
			end
			if (q.bitcnt == 3'h7) begin
				if (!q.op_wr) begin
					d.rbuf = nsh;
					d.rvld = 1'b1;
				end
				d.bytes = q.bytes - 16'h0001;
				if (q.bytes <= 16'h0001) begin
					d.post = 16'h0000;
					if (ecc_mode) d.eccc = gray_next(d.eccc);
					d.st   = ddds_pkg::ST_POST;
				end
			end
		end

		if ((abort || link.ready_n) && busy && (q.st != ddds_pkg::ST_END)) begin
			d.st = ddds_pkg::ST_END;
		end

		if (!ecc_mode) begin
			d.eccc = (q.itype == ddds_pkg::DDDS_FLOPPY && q.idx_sel) ? ddds_pkg::MARK_INDEX
			                                                        : ddds_pkg::MARK_NORMAL;
		end else if (d.st == ddds_pkg::ST_IDLE) begin
			d.eccc = ddds_pkg::ECC_IDLE;
		end

		d.hsel[1:0] = q.head[1:0];
		d.hsel[2]   = (q.itype == ddds_pkg::DDDS_FLOPPY) ? (d.st != ddds_pkg::ST_IDLE) : q.head[2];
		d.hsel[3]   = (q.itype == ddds_pkg::DDDS_FLOPPY) ? 1'b0 : q.head[3];
		d.wclk      = (q.itype == ddds_pkg::DDDS_ESDI) && link_ok && !link.refclk;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q         <= '0;
			q.st      <= ddds_pkg::ST_IDLE;
			q.itype   <= ddds_pkg::DDDS_FLOPPY;
			q.len     <= ddds_pkg::LEN_RESET;
			q.awready <= 1'b1;
			q.wready  <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready          = q.awready;
	assign s_axi_wready           = q.wready;
	assign s_axi_bresp            = q.bresp;
	assign s_axi_bvalid           = q.bvalid;
	assign s_axi_arready          = q.arready;
	assign s_axi_rdata            = q.rdata;
	assign s_axi_rresp            = q.rresp;
	assign s_axi_rvalid           = q.rvalid;
	assign head_number_out        = q.hsel;
	assign mark_control_out       = q.mctl;
	assign read_gate              = q.rg;
	assign write_gate             = q.wg;
	assign write_clock_out        = q.wclk;
	assign serial_write_out       = q.wdat;
	assign external_check_control = q.eccc;
endmodule

`default_nettype wire

/* File: sim/ddds_mon_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

module ddds_mon (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       read_reference_clock,
	input wire logic       mark_found_in,
	input wire logic [3:0] head_number_out,
	input wire logic       mark_control_out,
	input wire logic       read_gate,
	input wire logic       write_gate,
	input wire logic       write_clock_out,
	input wire logic       serial_write_out,
	input wire logic [1:0] external_check_control
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ecc01;
		external_check_control == 2'h1 |=> external_check_control inside {2'h1, 2'h3};
	endproperty
	a_ecc01: assert property (p_ecc01) else $error("ecc left reset badly");
	property p_ecc11;
		external_check_control == 2'h3 |=> external_check_control inside {2'h3, 2'h2};
	endproperty
	a_ecc11: assert property (p_ecc11) else $error("ecc left generate badly");
	// refclk stays high for six clocks, so two back it is still high after a synced rise
	property p_rg;
		$changed(read_gate) |-> $past(read_reference_clock, 2);
	endproperty
	a_rg: assert property (p_rg) else $error("read gate off refclk");
	property p_wg;
		$changed(write_gate) |-> $past(read_reference_clock, 2);
	endproperty
	a_wg: assert property (p_wg) else $error("write gate off refclk");
	property p_wd;
		$changed(serial_write_out) |-> $past(read_reference_clock, 2);
	endproperty
	a_wd: assert property (p_wd) else $error("write data off refclk");
	property p_wclk;
		$rose(write_clock_out) |-> $past(read_reference_clock, 3) == 1'b0;
	endproperty
	a_wclk: assert property (p_wclk) else $error("write clock not inverted");
	property p_hload;
		$rose(head_number_out[2]) |=> (!read_gate && !write_gate)[*7];
	endproperty
	a_hload: assert property (p_hload) else $error("gate before head load sample");
	property p_mark;
		$fell(mark_control_out) |-> $past(mark_found_in, 2);
	endproperty
	a_mark: assert property (p_mark) else $error("mark control dropped unanswered");
endmodule

bind ddds_top ddds_mon ddds_mon_inst (.aclk, .aresetn, .read_reference_clock, .mark_found_in,
	.head_number_out, .mark_control_out, .read_gate, .write_gate, .write_clock_out,
	.serial_write_out, .external_check_control);

`default_nettype wire

/* File: sim/ddds_sep_model.sv */
`timescale 1ns/1ns
`default_nettype none

module ddds_sep_model (
	input  wire logic       mark_control_out,
	input  wire logic       read_gate,
	input  wire logic       write_gate,
	input  wire logic       serial_write_out,
	input  wire logic [3:0] head_number_out,
	input  wire logic [1:0] external_check_control,
	input  wire logic [7:0] rd_byte,
	input  wire logic       err_en,
	output logic            read_reference_clock,
	output logic            mark_found_in,
	output logic            seek_complete_in,
	output logic            serial_read_in,
	output logic            external_check_error,
	output logic            drive_ready_ack_n,
	output logic [7:0]      cap_byte,
	output logic            cap_stb
);
	logic [3:0] cnt_q = 4'h0;
	logic [3:0] bit_q = 4'h9;
	logic [6:0] sh_q = 7'h00;

	initial begin
		read_reference_clock = 1'b0;
		mark_found_in = 1'b0;
		seek_complete_in = 1'b0;
		serial_read_in = 1'b0;
		cap_byte = 8'h00;
		cap_stb = 1'b0;
		drive_ready_ack_n = 1'b1;
		#200 drive_ready_ack_n = 1'b0;
	end

	// runs free from time zero, whatever the controller drives
	// edges kept off the system clock grid, so sampling never races
	always begin
		#61 read_reference_clock = 1'b1;
		#62 read_reference_clock = 1'b0;
		#2;
	end

	// head settles late, so the first sample finds seek complete low
	always @(head_number_out[2]) seek_complete_in <= #200 head_number_out[2];

	assign external_check_error = err_en && read_gate && external_check_control == 2'h2;

	always @(posedge read_reference_clock) begin
		cap_stb <= 1'b0;
		serial_read_in <= ~serial_read_in;
		if (!mark_control_out && !read_gate && !write_gate) begin
			mark_found_in <= 1'b0;
			cnt_q <= 4'h0;
		end else if ((mark_control_out || write_gate) && !mark_found_in) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'h2) begin
				mark_found_in <= 1'b1;
				bit_q <= 4'h1;
				serial_read_in <= rd_byte[7];
			end
		end
		if (mark_found_in && bit_q < 4'h9) begin
			bit_q <= bit_q + 4'h1;
			if (bit_q < 4'h8)
				serial_read_in <= rd_byte[3'h7 - bit_q[2:0]];
			sh_q <= {sh_q[5:0], serial_write_out};
			cap_byte <= {sh_q, serial_write_out};
			cap_stb <= write_gate && bit_q == 4'h8;
		end
	end
endmodule

`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [4:0]  s_axi_awaddr = 5'h00;
	logic [4:0]  s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, index_in = 1'b0, err_en = 1'b0;
	logic [7:0]  rd_byte = 8'h00;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp, external_check_control;
	wire logic [31:0] s_axi_rdata;
	wire logic   read_reference_clock, mark_found_in, seek_complete_in, serial_read_in;
	wire logic   external_check_error, drive_ready_ack_n, mark_control_out, read_gate;
	wire logic   write_gate, write_clock_out, serial_write_out, cap_stb;
	wire logic [3:0] head_number_out;
	wire logic [7:0] cap_byte;
	int          err_total = 0;
	int          n_compared = 0;
	logic [65:0] exp_q[$];
	logic [7:0]  wr_q[$];
	logic [65:0] e;
	logic [31:0] v;

	always #5 aclk = ~aclk;

	ddds_top #(.POSTAMBLE_BITS(4)) ddds_top_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .read_reference_clock, .index_in, .mark_found_in, .seek_complete_in,
		.serial_read_in, .external_check_error, .drive_ready_ack_n, .head_number_out,
		.mark_control_out, .read_gate, .write_gate, .write_clock_out, .serial_write_out,
		.external_check_control);

	ddds_sep_model ddds_sep_model_inst (.mark_control_out, .read_gate, .write_gate,
		.serial_write_out, .head_number_out, .external_check_control, .rd_byte, .err_en,
		.read_reference_clock, .mark_found_in, .seek_complete_in, .serial_read_in,
		.external_check_error, .drive_ready_ack_n, .cap_byte, .cap_stb);

	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic bail;
		err_total++;
		finish_test();
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_compared++;
		if (got !== ex) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
				break;
		end
		s_axi_bready <= 1'b0;
		if (i == 50)
			bail();
	endtask

	// the watcher below pairs each note with the read that answers it
	task automatic rd(input logic [4:0] a, input logic [1:0] r, input logic [31:0] ex,
		input logic [31:0] m);
		int i;
		@(posedge aclk);
		exp_q.push_back({r, ex, m});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
				break;
		end
		v = s_axi_rdata;
		s_axi_rready <= 1'b0;
		if (i == 50)
			bail();
	endtask

	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk("rresp", {30'h0, e[65:64]}, {30'h0, s_axi_rresp});
			chk("rdata", e[63:32], s_axi_rdata & e[31:0]);
		end
	end

	// byte leaves in the same event as the strobe, so let it land first
	always @(posedge cap_stb) begin
		#1;
		chk("wrdata", {24'h0, wr_q.pop_front()}, {24'h0, cap_byte});
	end

	task automatic op(input logic [1:0] it, input logic ec, input logic ix, input logic w);
		logic [3:0] hd;
		logic [7:0] b;
		int i;
		hd = 4'($urandom);
		b = 8'($urandom);
		wr(ddds_pkg::ADDR_CTRL, {20'h0, hd, 3'h0, ix && it == 2'h2, ix, ec, it});
		wr(ddds_pkg::ADDR_LEN, 32'h1);
		if (w) begin
			wr(ddds_pkg::ADDR_WDATA, {24'h0, b});
			wr_q.push_back(b);
		end
		rd_byte <= b;
		err_en <= ec;
		repeat (10) @(posedge aclk);
		chk("head", {28'h0, it == 2'h0 ? {2'h0, hd[1:0]} : hd}, {28'h0, head_number_out});
		wr(ddds_pkg::ADDR_CMD, w ? 32'h2 : 32'h1);
		for (i = 0; i < 300 && (mark_control_out | write_gate) !== 1'b1; i++)
			@(posedge aclk);
		if (i == 300)
			bail();
		@(posedge aclk);
		chk("hload", {31'h0, it == 2'h0 ? 1'b1 : hd[2]}, {31'h0, head_number_out[2]});
		chk("ecc", ec ? 32'h1 : (ix && it == 2'h0 ? 32'h0 : 32'h2), {30'h0, external_check_control});
		chk("gates", {30'h0, w, !w && it != 2'h2}, {30'h0, write_gate, read_gate});
		// long high index must still count once per revolution
		repeat (2) begin
			index_in <= 1'b1;
			repeat (15) @(posedge aclk);
			index_in <= 1'b0;
			repeat (15) @(posedge aclk);
		end
		v = 32'h1;
		for (i = 0; i < 200 && v[0] !== 1'b0; i++)
			rd(ddds_pkg::ADDR_STATUS, ddds_pkg::RESP_OKAY, 32'h0, 32'h0);
		if (i == 200)
			bail();
		rd(ddds_pkg::ADDR_STATUS, ddds_pkg::RESP_OKAY, {16'h0, 8'h02, 4'h0, ec & !w, 3'h0}, 32'hff08);
		if (!w)
			rd(ddds_pkg::ADDR_RDATA, ddds_pkg::RESP_OKAY, {24'h0, b}, 32'hff);
	endtask

	initial begin
		void'($urandom(32'hd7a9e002));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (40) @(posedge aclk);
		rd(ddds_pkg::ADDR_STATUS, ddds_pkg::RESP_OKAY, 32'h40, 32'h41);
		rd(ddds_pkg::ADDR_LEN, ddds_pkg::RESP_OKAY, 32'h200, 32'hffff);
		rd(5'h18, ddds_pkg::RESP_SLVERR, 32'h0, 32'h0);
		op(ddds_pkg::DDDS_FLOPPY, 1'b0, 1'b1, 1'b0);
		op(ddds_pkg::DDDS_MFM, 1'b1, 1'b0, 1'b0);
		op(ddds_pkg::DDDS_ESDI, 1'b0, 1'b0, 1'b1);
		op(ddds_pkg::DDDS_ESDI, 1'b0, 1'b1, 1'b1);
		repeat (5) @(posedge aclk);
		chk("queues", 32'h0, exp_q.size() + wr_q.size());
		finish_test();
	end

	initial begin
		repeat (50000) @(posedge aclk);
		bail();
	end
endmodule

`default_nettype wire
